// ===== design/vic_pkg.sv
// shared constants, carriers and state type of the vectored interrupt controller
package vic_pkg;

    localparam int NUM_USER = 118;
    localparam int NUM_TRAP = 5;
    localparam int FLAG_WORDS = 4;
    localparam int PRIO_WORDS = 15;
    localparam int SRC_PER_PRIO = 8;

    localparam logic [6:0] USER_VEC_BASE = 7'h08;
    localparam logic [6:0] TRAP_VEC_BASE = 7'h01;
    localparam logic [3:0] TRAP_TOP_LEVEL = 4'he;
    localparam logic [2:0] CPU_MASK_LEVEL = 3'h7;

    localparam logic [23:0] PRIMARY_TABLE_BASE = 24'h000004;
    localparam logic [23:0] ALT_OFFSET = 24'h000100;
    localparam logic [23:0] RESET_PC = 24'h000000;

    // implemented user sources, bit i is vector 8 + i
    localparam logic [127:0] IMPL_MASK = 128'h000000000000007e6000601fffdf7fff;

    localparam int EXT0_BIT = 0;
    localparam int EXT1_BIT = 20;
    localparam int EXT2_BIT = 29;
    localparam int ALT_BIT = 15;

    localparam logic [11:0] CTRL1_OFS = 12'h000;
    localparam logic [11:0] CTRL2_OFS = 12'h004;
    localparam logic [11:0] PEND_OFS = 12'h008;
    localparam logic [11:0] FLAG_OFS = 12'h010;
    localparam logic [11:0] ENA_OFS = 12'h020;
    localparam logic [11:0] PRIO_OFS = 12'h040;
    localparam logic [31:0] PRIO_WMASK = 32'h77777777;

    localparam logic [3:0] ENTRY_CYCLES = 4'h5;
    localparam logic [3:0] RETURN_CYCLES = 4'h3;

    typedef enum logic [1:0] {ST_IDLE, ST_ENTRY, ST_SERVE, ST_RETURN} svc_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic irq;
        logic [6:0] vector;
        logic [3:0] level;
        logic [23:0] fetchAddr;
        logic fetchStrobe;
        logic returnDone;
    } core_out_t;

    typedef struct packed {
        logic [127:0] flags;
        logic [127:0] enables;
        logic [PRIO_WORDS-1:0][31:0] prio;
        logic [NUM_TRAP-1:0] trapFlags;
        logic altSel;
        logic [6:0] pendVec;
        logic [3:0] pendLvl;
        logic [2:0] extMeta;
        logic [2:0] extSync;
        logic [2:0] extPrev;
        svc_state_t svc;
        logic [3:0] cnt;
        apb_rsp_t rsp;
        core_out_t core;
    } vic_state_t;

    // all zero: fetch address equals RESET_PC, service machine idle
    localparam vic_state_t VIC_RESET = '0;

endpackage

// ===== design/priority_pick.sv
// combinational winner selection among traps and user sources
`timescale 1ns/1ns
`default_nettype none
module priority_pick
    import vic_pkg::*;
(
    input wire logic [127:0] flags,
    input wire logic [127:0] enables,
    input wire logic [PRIO_WORDS-1:0][31:0] prio,
    input wire logic [NUM_TRAP-1:0] trapFlags,
    input wire logic [3:0] cpuLevel,
    output logic pickValid,
    output logic [6:0] pickVec,
    output logic [3:0] pickLvl
);

    function automatic logic [3:0] levelOf(input logic [PRIO_WORDS-1:0][31:0] p, input int i);
        levelOf = {1'b0, p[i / SRC_PER_PRIO][4 * (i % SRC_PER_PRIO) +: 3]};
    endfunction

    always_comb
    begin
        logic [3:0] lvl;
        lvl = '0;
        pickValid = 1'b0;
        pickVec = '0;
        pickLvl = '0;
        // cpu levels 7 and 15 block every user source
        if (cpuLevel[2:0] != CPU_MASK_LEVEL) // [R19]
        begin
            // downward scan with >= leaves the lowest vector on ties
            for (int i = NUM_USER - 1; i >= 0; i--)
            begin
                lvl = levelOf(prio, i);
                if (flags[i] && enables[i] && lvl > cpuLevel && lvl >= pickLvl) // [R7] [R17] [R20]
                begin
                    pickValid = 1'b1;
                    pickVec = 7'(USER_VEC_BASE + 7'(i)); // [R8]
                    pickLvl = lvl;
                end
            end
        end
        // traps sit above every user level, lower vector higher level
        for (int t = NUM_TRAP - 1; t >= 0; t--)
        begin
            lvl = 4'(TRAP_TOP_LEVEL - 4'(t));
            if (trapFlags[t] && lvl > cpuLevel && lvl >= pickLvl) // [R6]
            begin
                pickValid = 1'b1;
                pickVec = 7'(TRAP_VEC_BASE + 7'(t));
                pickLvl = lvl;
            end
        end
    end

endmodule // priority_pick
`default_nettype wire

// ===== design/vectored_interrupt_controller.sv
// vectored interrupt controller with apb registers and core request port
//
// How it works
// R1: all requests merge into one core request
// R2: each user source gets one of eight levels
// R3: primary table starts at word 0x000004
// R4: 126 vectors: eight traps, 118 user sources
// R5: entries hold 24-bit routine start addresses
// R6: lower vector number means higher natural priority
// R7: equal levels resolved by fixed natural order
// R8: every source has its own vector
// R9: entry and return take fixed cycle counts
// R10: 45 user sources and five traps implemented
// R11: select bit 15 switches to alternate table
// R12: alternate entry sits 0x100 above primary
// R13: reset clears state, fetch address zero
// R14: external request zero is vector 8
// R15: peripheral sources have fixed vectors, e.g. 18
// R16: flags set by source, cleared by software
// R17: disabled sources never reach the core
// R18: pending vector and level latched, readable
// R19: cpu level 7 or 15 masks users
// R20: eligible if flagged, enabled, above cpu level
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module vectored_interrupt_controller
    import vic_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire apb_req_t apbReq,
    output var apb_rsp_t apbRsp,
    input wire logic [NUM_USER-1:0] srcEvent,
    input wire logic [2:0] extRequestPin,
    input wire logic [NUM_TRAP-1:0] trapEvent,
    input wire logic [3:0] cpuPriorityLevel,
    input wire logic intAck,
    input wire logic intReturn,
    output var core_out_t coreOut
);

    vic_state_t st_r;
    vic_state_t st_nxt;

    logic pickValid;
    logic [6:0] pickVec;
    logic [3:0] pickLvl;

    // byte-lane merge of a written word
    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return res;
    endfunction

    // table entry address for a vector, primary or alternate
    function automatic logic [23:0] entryAddr(input logic [6:0] vec, input logic alt);
        logic [23:0] a;
        a = 24'(PRIMARY_TABLE_BASE + 24'({vec, 1'b0})); // [R3] [R5]
        if (alt) // [R11]
        begin
            a = 24'(a + ALT_OFFSET); // [R12]
        end
        return a;
    endfunction

    function automatic logic inRange(input logic [11:0] a, input logic [11:0] base, input int words);
        return (a >= base) && (32'(a) < 32'(base) + 32'(4 * words));
    endfunction

    function automatic logic isMapped(input logic [11:0] a);
        return (a[1:0] == 2'b00) && (a == CTRL1_OFS || a == CTRL2_OFS || a == PEND_OFS
               || inRange(a, FLAG_OFS, FLAG_WORDS) || inRange(a, ENA_OFS, FLAG_WORDS)
               || inRange(a, PRIO_OFS, PRIO_WORDS));
    endfunction

    function automatic logic [31:0] readWord(input vic_state_t s, input logic [11:0] a);
        logic [31:0] d;
        d = '0;
        if (a == CTRL1_OFS)
        begin
            d[NUM_TRAP-1:0] = s.trapFlags;
        end
        else if (a == CTRL2_OFS)
        begin
            d[ALT_BIT] = s.altSel;
        end
        else if (a == PEND_OFS)
        begin
            d[6:0] = s.pendVec; // [R18]
            d[11:8] = s.pendLvl;
        end
        for (int w = 0; w < FLAG_WORDS; w++)
        begin
            if (a == 12'(FLAG_OFS + 12'(4 * w)))
            begin
                d = s.flags[32*w +: 32];
            end
            if (a == 12'(ENA_OFS + 12'(4 * w)))
            begin
                d = s.enables[32*w +: 32];
            end
        end
        for (int w = 0; w < PRIO_WORDS; w++)
        begin
            if (a == 12'(PRIO_OFS + 12'(4 * w)))
            begin
                d = s.prio[w];
            end
        end
        return d;
    endfunction

    priority_pick u_pick (
        .flags(st_r.flags),
        .enables(st_r.enables),
        .prio(st_r.prio),
        .trapFlags(st_r.trapFlags),
        .cpuLevel(cpuPriorityLevel),
        .pickValid(pickValid),
        .pickVec(pickVec),
        .pickLvl(pickLvl)
    );

    always_comb
    begin
        logic [2:0] extRise;
        logic [127:0] evt;
        logic access;
        logic commit;
        logic [11:0] addr;
        logic [31:0] merged;
        extRise = '0;
        evt = '0;
        access = 1'b0;
        commit = 1'b0;
        addr = apbReq.paddr;
        merged = '0;
        st_nxt = st_r;

        // external pins: two-stage synchroniser, then rising edge
        st_nxt.extMeta = extRequestPin;
        st_nxt.extSync = st_r.extMeta;
        st_nxt.extPrev = st_r.extSync;
        extRise = st_r.extSync & ~st_r.extPrev;
        evt = 128'(srcEvent);
        evt[EXT0_BIT] = evt[EXT0_BIT] | extRise[0]; // [R14]
        evt[EXT1_BIT] = evt[EXT1_BIT] | extRise[1];
        evt[EXT2_BIT] = evt[EXT2_BIT] | extRise[2];

        // apb: answer one cycle into access, commit on the ready edge
        access = apbReq.psel && apbReq.penable;
        st_nxt.rsp.pready = 1'b0;
        if (access && !st_r.rsp.pready)
        begin
            st_nxt.rsp.pready = 1'b1;
            st_nxt.rsp.prdata = readWord(st_r, addr);
            st_nxt.rsp.pslverr = !isMapped(addr);
        end
        commit = access && st_r.rsp.pready && apbReq.pwrite && isMapped(addr);

        if (commit && addr == CTRL1_OFS)
        begin
            merged = mergeBytes(32'(st_r.trapFlags), apbReq.pwdata, apbReq.pstrb);
            st_nxt.trapFlags = merged[NUM_TRAP-1:0];
        end
        if (commit && addr == CTRL2_OFS)
        begin
            merged = mergeBytes({16'h0000, st_r.altSel, 15'h0000}, apbReq.pwdata, apbReq.pstrb);
            st_nxt.altSel = merged[ALT_BIT]; // [R11]
        end
        for (int w = 0; w < FLAG_WORDS; w++)
        begin
            if (commit && addr == 12'(FLAG_OFS + 12'(4 * w)))
            begin
                st_nxt.flags[32*w +: 32] = mergeBytes(st_r.flags[32*w +: 32], apbReq.pwdata,
                                                      apbReq.pstrb); // [R16]
            end
            if (commit && addr == 12'(ENA_OFS + 12'(4 * w)))
            begin
                st_nxt.enables[32*w +: 32] = mergeBytes(st_r.enables[32*w +: 32], apbReq.pwdata,
                                                        apbReq.pstrb); // [R17]
            end
        end
        for (int w = 0; w < PRIO_WORDS; w++)
        begin
            if (commit && addr == 12'(PRIO_OFS + 12'(4 * w)))
            begin
                st_nxt.prio[w] = mergeBytes(st_r.prio[w], apbReq.pwdata, apbReq.pstrb)
                                 & PRIO_WMASK; // [R2]
            end
        end

        // hardware set wins over a software clear in the same cycle
        st_nxt.flags = (st_nxt.flags | evt) & IMPL_MASK; // [R10] [R15] [R16]
        st_nxt.enables = st_nxt.enables & IMPL_MASK;
        st_nxt.trapFlags = st_nxt.trapFlags | trapEvent; // [R4] [R10]

        if (pickValid)
        begin
            st_nxt.pendVec = pickVec; // [R18]
            st_nxt.pendLvl = pickLvl;
        end

        // service sequencing with fixed entry and return latency
        st_nxt.core.fetchStrobe = 1'b0;
        st_nxt.core.returnDone = 1'b0;
        case (st_r.svc)
            ST_IDLE:
            begin
                st_nxt.core.irq = pickValid; // [R1]
                st_nxt.core.vector = pickVec;
                st_nxt.core.level = pickLvl;
                st_nxt.core.fetchAddr = entryAddr(pickVec, st_r.altSel); // [R11] [R12]
                if (intAck && st_r.core.irq)
                begin
                    st_nxt.core.irq = 1'b0;
                    st_nxt.core.vector = st_r.core.vector;
                    st_nxt.core.level = st_r.core.level;
                    st_nxt.core.fetchAddr = st_r.core.fetchAddr;
                    st_nxt.cnt = 4'(ENTRY_CYCLES - 4'h1); // [R9]
                    st_nxt.svc = ST_ENTRY;
                end
            end
            ST_ENTRY:
            begin
                st_nxt.cnt = 4'(st_r.cnt - 4'h1);
                if (st_r.cnt == 4'h0)
                begin
                    st_nxt.cnt = '0;
                    st_nxt.core.fetchStrobe = 1'b1; // [R9]
                    st_nxt.svc = ST_SERVE;
                end
            end
            ST_SERVE:
            begin
                if (intReturn)
                begin
                    st_nxt.cnt = 4'(RETURN_CYCLES - 4'h1); // [R9]
                    st_nxt.svc = ST_RETURN;
                end
            end
            ST_RETURN:
            begin
                st_nxt.cnt = 4'(st_r.cnt - 4'h1);
                if (st_r.cnt == 4'h0)
                begin
                    st_nxt.cnt = '0;
                    st_nxt.core.returnDone = 1'b1; // [R9]
                    st_nxt.svc = ST_IDLE;
                end
            end
            default:
            begin
                st_nxt.svc = ST_IDLE;
                st_nxt.cnt = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_r <= VIC_RESET; // [R13]
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign apbRsp = st_r.rsp;
    assign coreOut = st_r.core;

endmodule // vectored_interrupt_controller
`default_nettype wire

// ===== dv/vic_props.sv
// port checker for the vectored interrupt controller
`timescale 1ns/1ns
`default_nettype none
module vic_props
    import vic_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire apb_req_t apbReq,
    input wire apb_rsp_t apbRsp,
    input wire logic [NUM_USER-1:0] srcEvent,
    input wire logic [2:0] extRequestPin,
    input wire logic [NUM_TRAP-1:0] trapEvent,
    input wire logic [3:0] cpuPriorityLevel,
    input wire logic intAck,
    input wire logic intReturn,
    input wire core_out_t coreOut
);
    logic altSel_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // last written table select
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            altSel_r <= 1'b0;
        else if (apbReq.penable && apbRsp.pready && apbReq.pwrite && apbReq.paddr == CTRL2_OFS)
            altSel_r <= apbReq.pwdata[ALT_BIT];
    end
    req_merge_a: assert property (intAck && coreOut.irq |=> !coreOut.irq)
        else $error("irq kept after ack");
    entry_fixed_a: assert property (intAck && coreOut.irq |=>
        !coreOut.fetchStrobe [*5] ##1 coreOut.fetchStrobe)
        else $error("entry latency wrong");
    return_fixed_a: assert property (coreOut.fetchStrobe ##[1:20] intReturn
        |=> !coreOut.returnDone [*3] ##1 coreOut.returnDone)
        else $error("return latency wrong");
    table_addr_a: assert property (coreOut.fetchStrobe |-> coreOut.fetchAddr ==
        PRIMARY_TABLE_BASE + {16'h0, coreOut.vector, 1'b0} + (altSel_r ? ALT_OFFSET : 24'h0))
        else $error("fetch address wrong");
    trap_level_a: assert property (coreOut.irq && coreOut.vector < USER_VEC_BASE
        |-> coreOut.vector >= TRAP_VEC_BASE && coreOut.level == 4'hf - coreOut.vector[3:0])
        else $error("trap vector or level wrong");
    user_level_a: assert property (coreOut.irq && coreOut.vector >= USER_VEC_BASE
        |-> coreOut.level inside {[4'h1:4'h7]})
        else $error("user level out of range");
    user_mask_a: assert property (coreOut.irq && $past(cpuPriorityLevel[2:0]) == CPU_MASK_LEVEL
        |-> coreOut.vector < USER_VEC_BASE)
        else $error("user irq while masked");
    above_cpu_a: assert property (coreOut.irq |-> coreOut.level > $past(cpuPriorityLevel))
        else $error("irq not above cpu level");
    cover property (coreOut.fetchStrobe && altSel_r);
    cover property (coreOut.returnDone);
    cover property (coreOut.irq && coreOut.vector < USER_VEC_BASE);
endmodule // vic_props
bind vectored_interrupt_controller vic_props chk (.sys_clk(sys_clk), .reset_n(reset_n), .apbReq(apbReq),
    .apbRsp(apbRsp), .srcEvent(srcEvent), .extRequestPin(extRequestPin), .trapEvent(trapEvent),
    .cpuPriorityLevel(cpuPriorityLevel), .intAck(intAck), .intReturn(intReturn), .coreOut(coreOut));
`default_nettype wire

// ===== dv/core_model.sv
// processor core that takes, enters and leaves interrupts
`timescale 1ns/1ns
`default_nettype none
module core_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic irq,
    output logic intAck,
    output logic intReturn
);
    int seed = 95;
    initial
    begin
        intAck = 1'b0;
        intReturn = 1'b0;
        forever
        begin
            @(posedge sys_clk);
            if (reset_n && irq === 1'b1)
            begin
                repeat ($unsigned($random(seed)) % 3) @(posedge sys_clk);
                intAck <= 1'b1;
                @(posedge sys_clk);
                intAck <= 1'b0;
                repeat (12 + $unsigned($random(seed)) % 4) @(posedge sys_clk);
                intReturn <= 1'b1;
                @(posedge sys_clk);
                intReturn <= 1'b0;
                repeat (5) @(posedge sys_clk);
            end
        end
    end
endmodule // core_model
`default_nettype wire

// ===== dv/tb_vectored_interrupt_controller.sv
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ns
`default_nettype none
module tb_vectored_interrupt_controller
    import vic_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    core_out_t co;
    logic [NUM_USER-1:0] srcEvent = '0;
    logic [2:0] extPin = '0;
    logic [NUM_TRAP-1:0] trapEvent = '0;
    logic [3:0] cpuLvl = 4'hf;
    logic intAck, intReturn, e;
    logic [31:0] q, d;
    int badCount = 0, checks = 0, cyc = 0, seed = 95, expLvl, v, altM, cpu;
    int flagM[128], enM[128], prM[128], trapM[NUM_TRAP];
    vectored_interrupt_controller uut (.sys_clk(sys_clk), .reset_n(reset_n), .apbReq(req), .apbRsp(rsp),
        .srcEvent(srcEvent), .extRequestPin(extPin), .trapEvent(trapEvent), .cpuPriorityLevel(cpuLvl),
        .intAck(intAck), .intReturn(intReturn), .coreOut(co));
    core_model core (.sys_clk(sys_clk), .reset_n(reset_n), .irq(co.irq), .intAck(intAck),
        .intReturn(intReturn));
    initial
        forever #50 sys_clk = ~sys_clk;
    task automatic close_out();
        if (badCount == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            badCount++;
            close_out();
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            badCount++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd, pstrb: 4'hf};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (rsp.pready !== 1'b1);
        q = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
    endtask
    function automatic int pick(int c);
        int best;
        best = -1;
        expLvl = 0;
        for (int t = 0; t < NUM_TRAP; t++)
            if (trapM[t] != 0 && 14 - t > c && 14 - t > expLvl)
            begin
                best = 1 + t;
                expLvl = 14 - t;
            end
        for (int i = 0; i < NUM_USER; i++)
            if (c % 8 != 7 && flagM[i] != 0 && enM[i] != 0 && prM[i] > c && prM[i] > expLvl)
            begin
                best = 8 + i;
                expLvl = prM[i];
            end
        return best;
    endfunction
    function automatic logic [31:0] fw(int n);
        for (int b = 0; b < 32; b++)
            fw[b] = (n < 8) ? (b < NUM_TRAP && trapM[b % NUM_TRAP] != 0) : (flagM[(n-8)/32*32+b] != 0);
    endfunction
    task automatic round(int r);
        int i;
        cpuLvl <= 4'hf;
        altM = r % 2;
        apb(1'b1, CTRL2_OFS, 32'(altM) << ALT_BIT);
        apb(1'b1, ENA_OFS, (r == 4) ? 32'h0 : 32'hffffffff);
        for (int k = 0; k < 128; k++)
            enM[k] = IMPL_MASK[k] && (k >= 32 || r != 4);
        extPin <= (r == 2) ? 3'h7 : 3'h0;
        flagM[EXT0_BIT] = (r == 2);
        flagM[EXT1_BIT] = (r == 2);
        flagM[EXT2_BIT] = (r == 2);
        trapEvent[r % NUM_TRAP] <= 1'b1;
        trapM[r % NUM_TRAP] = 1;
        for (int k = 0; k < 5; k++)
        begin
            i = $unsigned($random(seed)) % NUM_USER;
            srcEvent[i] <= 1'b1;
            flagM[i] = flagM[i] | IMPL_MASK[i];
        end
        @(posedge sys_clk);
        srcEvent <= '0;
        trapEvent <= '0;
        repeat (5) @(posedge sys_clk);
        extPin <= '0;
        apb(1'b0, FLAG_OFS, 32'h0);
        cmp(q, fw(8));
        cpu = (r == 5) ? 7 : $unsigned($random(seed)) % 7;
        cpuLvl <= 4'(cpu);
        forever
        begin
            v = pick(cpu);
            if (v < 0)
                break;
            @(negedge sys_clk iff co.fetchStrobe === 1'b1);
            cmp(co.vector, v);
            cmp(co.fetchAddr, PRIMARY_TABLE_BASE + 2 * v + altM * ALT_OFFSET);
            cmp(co.level, expLvl);
            apb(1'b0, PEND_OFS, 32'h0);
            cmp(q[11:0], {expLvl[3:0], 1'b0, v[6:0]});
            if (v < 8)
                trapM[v-1] = 0;
            else
                flagM[v-8] = 0;
            apb(1'b1, (v < 8) ? CTRL1_OFS : FLAG_OFS + 12'((v - 8) / 32 * 4), fw(v));
        end
        repeat (12) @(negedge sys_clk);
        cmp(co.irq, 1'b0);
        @(posedge sys_clk);
        cpuLvl <= 4'hf;
        for (int w = 0; w < FLAG_WORDS; w++)
            apb(1'b1, FLAG_OFS + 12'(4 * w), 32'h0);
        apb(1'b1, CTRL1_OFS, 32'h0);
        flagM = '{default: 0};
        trapM = '{default: 0};
    endtask
    initial
    begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(negedge sys_clk);
        cmp(co.fetchAddr, RESET_PC);
        apb(1'b0, PEND_OFS, 32'h0);
        cmp(q, 32'h0);
        apb(1'b0, 12'h0f0, 32'h0);
        cmp(q, 32'h0);
        cmp(32'(e), 32'h1);
        for (int w = 0; w < PRIO_WORDS; w++)
        begin
            d = $random(seed);
            apb(1'b1, PRIO_OFS + 12'(4 * w), d);
            apb(1'b0, PRIO_OFS + 12'(4 * w), 32'h0);
            cmp(q, d & PRIO_WMASK);
            for (int j = 0; j < 8; j++)
                prM[8*w+j] = d[4*j+:3];
            if (w < FLAG_WORDS)
            begin
                apb(1'b1, ENA_OFS + 12'(4 * w), d);
                apb(1'b0, ENA_OFS + 12'(4 * w), 32'h0);
                cmp(q, d & IMPL_MASK[32*w+:32]);
                apb(1'b1, ENA_OFS + 12'(4 * w), 32'hffffffff);
            end
        end
        for (int r = 0; r < 8; r++)
            round(r);
        close_out();
    end
endmodule // tb_vectored_interrupt_controller
`default_nettype wire
